/* common/fpc_pkg.sv */
// Constants, types and pin bundles for the flash protect and power host controller.
`default_nettype none

package fpc_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;

    // Timing figures in nanoseconds; plain defaults for the attached part.
    localparam int CLK_PERIOD_NS = 100;
    localparam int RECOVERY_NS = 1000;
    localparam int ACCESS_NS = 200;
    localparam int WE_PULSE_NS = 100;
    // Least times round up to whole clock cycles.
    localparam logic [CNT_W-1:0] REC_CYC =
        CNT_W'((RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACC_CYC =
        CNT_W'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WE_CYC =
        CNT_W'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Flash command codes.
    localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 16'h00FF;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h0040;
    localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0020;
    localparam logic [DATA_W-1:0] CMD_CONFIRM = 16'h00D0;
    localparam logic [DATA_W-1:0] CMD_READ_STATUS = 16'h0070;
    localparam logic [DATA_W-1:0] CMD_CLEAR_STATUS = 16'h0050;

    // Status bit positions.
    localparam int SR_READY_BIT = 7;
    localparam int SR_SUPPLY_FAULT_BIT = 3;

    localparam logic [2:0] PH_POLL = 3'h2;

    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_ERASE, OP_STATUS, OP_CLEAR, OP_SLEEP
    } fpc_op_e;

    typedef enum logic [1:0] {ACT_WR, ACT_RD, ACT_END} fpc_act_e;

    typedef enum logic [2:0] {
        S_RECOVER, S_IDLE, S_DISP, S_WR_SET, S_WR_LO, S_WR_HI, S_RD
    } fpc_state_e;

    typedef struct packed {
        fpc_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fpc_req_s;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic wp_n;
        logic reset_powerdown_n;
        logic vpp_en;
    } fpc_ctl_s;

endpackage : fpc_pkg

`default_nettype wire

/* verilog/fpc_host.sv */
// Host-side controller that sequences commands, power-down and recovery on a word-wide flash.
`default_nettype none

module fpc_host
    import fpc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic REQ_VALID,
    input wire fpc_req_s REQ,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_DATA,
    output logic [DATA_W-1:0] RSP_STATUS,
    output logic RSP_SUPPLY_FAULT,
    input wire logic WRITE_PROTECT,
    input wire logic PROG_SUPPLY_EN,
    output var fpc_ctl_s FLASH_CTL,
    output logic [ADDR_W-1:0] FLASH_ADDR,
    output logic [DATA_W-1:0] FLASH_DQ_O,
    output logic FLASH_DQ_OE_N,
    input wire logic [DATA_W-1:0] FLASH_DQ_I
);

    typedef struct packed {
        fpc_state_e st;
        fpc_op_e op;
        logic pend;
        logic [2:0] phase;
        logic [CNT_W-1:0] cnt;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] status;
        logic ready;
        logic rsp_valid;
        fpc_ctl_s ctl;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic dq_oe_n;
    } fpc_core_s;

    // ------------------------------------------------------------------
    // Reset state
    // ------------------------------------------------------------------
    // Flash reset is held low while the host is in reset, so the flash
    // always comes back in read-array mode together with the host.
    localparam fpc_core_s CORE_RESET = '{
        st: S_RECOVER, op: OP_READ, pend: 1'b0, phase: 3'h0, cnt: '0,
        wdata: '0, rdata: '0, status: '0, ready: 1'b0, rsp_valid: 1'b0,
        ctl: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, wp_n: 1'b0, reset_powerdown_n: 1'b0,
               vpp_en: 1'b0},
        addr: '0, dq_o: '0, dq_oe_n: 1'b1};

    fpc_core_s core_reg;
    fpc_core_s core_next;
    fpc_act_e act;
    logic [DATA_W-1:0] act_data;

    // ------------------------------------------------------------------
    // Command sequences
    // ------------------------------------------------------------------
    // Each operation is a short list of bus cycles; phase selects the step.
    always_comb begin
        act = ACT_END;
        act_data = CMD_READ_ARRAY;
        case (core_reg.op)
            OP_READ: begin
                if (core_reg.phase == 3'h0) begin
                    act = ACT_RD;
                end
            end
            OP_PROGRAM, OP_ERASE: begin
                case (core_reg.phase)
                    3'h0: begin
                        act = ACT_WR;
                        act_data = (core_reg.op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE;
                    end
                    3'h1: begin
                        act = ACT_WR;
                        act_data = (core_reg.op == OP_PROGRAM) ? core_reg.wdata : CMD_CONFIRM;
                    end
                    PH_POLL: begin
                        act = ACT_RD;
                    end
                    3'h3: begin
                        // The flash is put back in read-array mode before the job ends.
                        act = ACT_WR;
                        act_data = CMD_READ_ARRAY;
                    end
                    default: begin
                        act = ACT_END;
                    end
                endcase
            end
            OP_STATUS: begin
                case (core_reg.phase)
                    3'h0: begin
                        act = ACT_WR;
                        act_data = CMD_READ_STATUS;
                    end
                    3'h1: begin
                        act = ACT_RD;
                    end
                    3'h2: begin
                        act = ACT_WR;
                        act_data = CMD_READ_ARRAY;
                    end
                    default: begin
                        act = ACT_END;
                    end
                endcase
            end
            OP_CLEAR: begin
                if (core_reg.phase == 3'h0) begin
                    act = ACT_WR;
                    act_data = CMD_CLEAR_STATUS;
                end
            end
            default: begin
                act = ACT_END;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        core_next = core_reg;
        core_next.rsp_valid = 1'b0;
        core_next.ctl.wp_n = ~WRITE_PROTECT;
        core_next.ctl.vpp_en = PROG_SUPPLY_EN;
        case (core_reg.st)
            S_RECOVER: begin
                // No read is started until the flash has had its recovery time.
                core_next.ctl.reset_powerdown_n = 1'b1;
                if (core_reg.cnt == REC_CYC) begin
                    core_next.cnt = '0;
                    core_next.st = core_reg.pend ? S_DISP : S_IDLE;
                    core_next.pend = 1'b0;
                end else begin
                    core_next.cnt = core_reg.cnt + 1'b1;
                end
            end
            S_IDLE: begin
                if (REQ_VALID) begin
                    core_next.op = REQ.op;
                    core_next.addr = REQ.addr;
                    core_next.wdata = REQ.wdata;
                    core_next.phase = 3'h0;
                    if (REQ.op == OP_SLEEP) begin
                        core_next.ctl.reset_powerdown_n = 1'b0;
                        core_next.rsp_valid = 1'b1;
                    end else if (!core_reg.ctl.reset_powerdown_n) begin
                        core_next.ctl.reset_powerdown_n = 1'b1;
                        core_next.pend = 1'b1;
                        core_next.cnt = '0;
                        core_next.st = S_RECOVER;
                    end else begin
                        core_next.st = S_DISP;
                    end
                end
            end
            S_DISP: begin
                core_next.cnt = '0;
                case (act)
                    ACT_WR: begin
                        core_next.ctl.ce_n = 1'b0;
                        core_next.dq_o = act_data;
                        core_next.dq_oe_n = 1'b0;
                        core_next.st = S_WR_SET;
                    end
                    ACT_RD: begin
                        core_next.ctl.ce_n = 1'b0;
                        core_next.ctl.oe_n = 1'b0;
                        core_next.st = S_RD;
                    end
                    default: begin
                        core_next.rsp_valid = 1'b1;
                        core_next.st = S_IDLE;
                    end
                endcase
            end
            S_WR_SET: begin
                // Strobe falls only once select is already low.
                core_next.ctl.we_n = 1'b0;
                core_next.cnt = 8'h01;
                core_next.st = S_WR_LO;
            end
            S_WR_LO: begin
                if (core_reg.cnt >= WE_CYC) begin
                    core_next.ctl.we_n = 1'b1;
                    core_next.st = S_WR_HI;
                end else begin
                    core_next.cnt = core_reg.cnt + 1'b1;
                end
            end
            S_WR_HI: begin
                // Select rises a cycle after the strobe, so data holds past it.
                core_next.ctl.ce_n = 1'b1;
                core_next.dq_oe_n = 1'b1;
                core_next.phase = core_reg.phase + 1'b1;
                core_next.st = S_DISP;
            end
            S_RD: begin
                if (core_reg.cnt + 1'b1 >= ACC_CYC) begin
                    core_next.ctl.ce_n = 1'b1;
                    core_next.ctl.oe_n = 1'b1;
                    core_next.rdata = FLASH_DQ_I;
                    core_next.st = S_DISP;
                    core_next.phase = core_reg.phase + 1'b1;
                    if (core_reg.op != OP_READ) begin
                        core_next.status = FLASH_DQ_I;
                    end
                    if ((core_reg.op == OP_PROGRAM || core_reg.op == OP_ERASE) &&
                        !FLASH_DQ_I[SR_READY_BIT]) begin
                        core_next.phase = core_reg.phase;
                    end
                end else begin
                    core_next.cnt = core_reg.cnt + 1'b1;
                end
            end
            default: begin
                core_next.st = S_IDLE;
            end
        endcase
        core_next.ready = (core_next.st == S_IDLE);
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            core_reg <= CORE_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    assign REQ_READY = core_reg.ready;
    assign RSP_VALID = core_reg.rsp_valid;
    assign RSP_DATA = core_reg.rdata;
    assign RSP_STATUS = core_reg.status;
    assign RSP_SUPPLY_FAULT = core_reg.status[SR_SUPPLY_FAULT_BIT];
    assign FLASH_CTL = core_reg.ctl;
    assign FLASH_ADDR = core_reg.addr;
    assign FLASH_DQ_O = core_reg.dq_o;
    assign FLASH_DQ_OE_N = core_reg.dq_oe_n;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] since_wake;
    logic [DATA_W-1:0] last_cmd;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            since_wake <= '0;
            last_cmd <= '0;
        end else begin
            if (!core_reg.ctl.reset_powerdown_n) begin
                since_wake <= '0;
            end else if (since_wake != 8'hFF) begin
                since_wake <= since_wake + 1'b1;
            end
            if (core_reg.ctl.we_n && !core_next.ctl.we_n) begin
                last_cmd <= core_reg.dq_o;
            end
        end
    end

    a_recovery_wait: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !core_reg.ctl.oe_n |-> since_wake >= REC_CYC)
        else $error("Read started before flash recovery time.");
    a_strobe_select: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !core_reg.ctl.we_n |-> !core_reg.ctl.ce_n && core_reg.ctl.oe_n)
        else $error("Write strobe low without select or with output enable.");
    a_strobe_length: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        $fell(core_reg.ctl.we_n) |-> !core_reg.dq_oe_n throughout
            (!core_reg.ctl.we_n [*1] ##1 core_reg.ctl.we_n))
        else $error("Write data not driven across the strobe.");
    a_read_array_after: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        core_reg.rsp_valid && (core_reg.op == OP_PROGRAM || core_reg.op == OP_ERASE)
            |-> last_cmd == CMD_READ_ARRAY)
        else $error("Program or erase ended without read-array command.");
    a_reset_powerdown: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !$past(RST_B) |-> !core_reg.ctl.reset_powerdown_n ##1 core_reg.ctl.reset_powerdown_n)
        else $error("Flash reset did not follow host reset.");

    c_program_done: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        core_reg.rsp_valid && core_reg.op == OP_PROGRAM);
    c_erase_poll: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        core_reg.st == S_RD && core_next.st == S_DISP && core_reg.op == OP_ERASE &&
            core_next.phase == PH_POLL);
    c_sleep_wake: cover property (@(posedge REF_CLK) disable iff (!RST_B)
        core_reg.st == S_RECOVER && core_reg.pend);

endmodule : fpc_host

`default_nettype wire

/* bench/fpc_flash_model.sv */
// Behavioural word-wide flash: locking, power modes and a two-step command set.
`default_nettype none

module fpc_flash_model
    import fpc_pkg::*;
#(
    parameter int BUSY_NS = 500,
    parameter logic [ADDR_W-1:0] LOCK_END = 20'h02000
)
(
    input wire fpc_ctl_s ctl,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_host,
    input wire logic dq_host_oe_n,
    output logic [DATA_W-1:0] dq_flash
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [DATA_W-1:0] mem [int];
    logic [1:0] mode = 2'h0; // Changed only by command writes and reset.
    logic [7:0] sr = 8'h80;
    logic [7:0] err;
    logic [DATA_W-1:0] last = 16'h0000;
    logic woke = 1'b0;
    int op_addr = -1;
    event op_start;

    function automatic logic [DATA_W-1:0] word(input logic [ADDR_W-1:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
    endfunction

    // ----------------------------------------------------------------
    // Command interface
    // ----------------------------------------------------------------
    always @(posedge ctl.we_n) begin
        if (ctl.reset_powerdown_n && !ctl.ce_n && !dq_host_oe_n) begin
            if (mode[1]) begin
                err = mode[0] ? 8'h20 : 8'h10;
                if (!ctl.vpp_en)
                    sr |= err | 8'h08;
                else if (!ctl.wp_n && addr < LOCK_END)
                    sr |= err | 8'h02;
                else if (!mode[0])
                    mem[int'(addr)] = word(addr) & dq_host;
                else if (dq_host == CMD_CONFIRM) begin
                    // Erase granule is 4K words everywhere, which is enough for these tests.
                    foreach (mem[k])
                        if ((k >> 12) == (int'(addr) >> 12))
                            mem[k] = 16'hFFFF;
                end
                mode = 2'h1; // Stays in status reads until told otherwise.
                sr[7] = 1'b0;
                op_addr = int'(addr);
                -> op_start;
            end else begin
                case (dq_host)
                    CMD_READ_ARRAY: mode = 2'h0;
                    CMD_READ_STATUS: mode = 2'h1;
                    CMD_CLEAR_STATUS: sr &= 8'h80;
                    CMD_PROGRAM: mode = 2'h2;
                    CMD_ERASE: mode = 2'h3;
                    default: mode = mode;
                endcase
            end
        end
    end

    always @(op_start) begin
        #(BUSY_NS); // Select may rise meanwhile; the operation still completes.
        if (op_addr >= 0)
            sr[7] = 1'b1;
        op_addr = -1;
    end

    always @(negedge ctl.reset_powerdown_n) begin
        if (op_addr >= 0)
            mem[op_addr] = 16'h0BAD;
        op_addr = -1;
        sr = 8'h80;
        mode = 2'h0;
        woke = 1'b0;
    end

    always @(posedge ctl.reset_powerdown_n) begin
        #(RECOVERY_NS);
        woke = ctl.reset_powerdown_n;
    end

    always @(ctl or addr or mode or sr or woke) begin
        if (ctl.reset_powerdown_n && woke && !ctl.ce_n && !ctl.oe_n) begin
            last = mode == 2'h0 ? word(addr) : {8'h00, sr};
            dq_flash = last; // Held while the address stands in read-array mode; status reads follow sr.
        end else begin
            // Floating lines have no pull, so show the inverse and stale data cannot pass.
            dq_flash = ~last;
        end
    end

endmodule // fpc_flash_model

`default_nettype wire

/* bench/fpc_host_tb.sv */
// Self-checking bench for the flash protect and power host controller.
`default_nettype none

module fpc_host_tb
    import fpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    fpc_req_s req = '0;
    logic write_protect = 1'b0;
    logic prog_supply_en = 1'b1;
    logic req_ready, rsp_valid, rsp_fault, dq_oe_n;
    logic [DATA_W-1:0] rsp_data, rsp_status, dq_o, dq_i;
    logic [ADDR_W-1:0] flash_addr;
    fpc_ctl_s ctl;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int lat;

    fpc_host dut_u (
        .REF_CLK(ref_clk), .RST_B(rst_b), .REQ_VALID(req_valid), .REQ(req),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .RSP_STATUS(rsp_status), .RSP_SUPPLY_FAULT(rsp_fault),
        .WRITE_PROTECT(write_protect), .PROG_SUPPLY_EN(prog_supply_en),
        .FLASH_CTL(ctl), .FLASH_ADDR(flash_addr), .FLASH_DQ_O(dq_o),
        .FLASH_DQ_OE_N(dq_oe_n), .FLASH_DQ_I(dq_i)
    );

    fpc_flash_model flash_u (
        .ctl(ctl), .addr(flash_addr), .dq_host(dq_o), .dq_host_oe_n(dq_oe_n), .dq_flash(dq_i)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Latency counts falling edges from the taking edge up to the response.
    task automatic run_op(input fpc_op_e op, input logic [19:0] a, input logic [15:0] d);
        while (req_ready !== 1'b1)
            @(negedge ref_clk);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{op: op, addr: a, wdata: d};
        @(posedge ref_clk);
        req_valid <= 1'b0;
        lat = 0;
        do begin
            @(negedge ref_clk);
            lat++;
        end while (rsp_valid !== 1'b1);
    endtask

    task automatic rd_chk(input logic [19:0] a, input logic [15:0] exp);
        run_op(OP_READ, a, 16'h0000);
        chk(rsp_data, exp);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end

    always @(negedge ref_clk)
        if (ctl.we_n === 1'b0)
            chk({ctl.ce_n, dq_oe_n}, 0);

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        repeat (20) @(posedge ref_clk);
        chk({ctl.reset_powerdown_n, ctl.wp_n, ctl.vpp_en}, 0);
        rst_b <= 1'b1;
        lat = 0;
        do begin
            @(negedge ref_clk);
            lat++;
        end while (req_ready !== 1'b1 && lat < 50);
        chk(lat, 12);
    endtask

    task automatic t_program();
        run_op(OP_PROGRAM, 20'h08010, 16'h1234);
        chk(rsp_status, 16'h0080);
        rd_chk(20'h08010, 16'h1234);
        chk(lat, 5);
        rd_chk(20'h08010, 16'h1234);
    endtask

    task automatic t_lock();
        @(posedge ref_clk);
        write_protect <= 1'b1;
        run_op(OP_PROGRAM, 20'h00010, 16'h5555);
        chk(rsp_status, 16'h0092);
        rd_chk(20'h00010, 16'hFFFF);
        // Error bits are sticky, so clear them before the next locked attempt.
        run_op(OP_CLEAR, 20'h00000, 16'h0000);
        chk(lat, 6);
        run_op(OP_ERASE, 20'h01000, 16'h0000);
        chk(rsp_status, 16'h00A2);
        run_op(OP_CLEAR, 20'h00000, 16'h0000);
        run_op(OP_PROGRAM, 20'h09020, 16'hA5A5);
        chk(rsp_status, 16'h0080);
        rd_chk(20'h09020, 16'hA5A5);
    endtask

    task automatic t_supply();
        @(posedge ref_clk);
        prog_supply_en <= 1'b0;
        write_protect <= 1'b0;
        run_op(OP_ERASE, 20'h08010, 16'h0000);
        chk({rsp_fault, rsp_status}, {1'b1, 16'h00A8});
        rd_chk(20'h08010, 16'h1234);
        @(posedge ref_clk);
        prog_supply_en <= 1'b1;
        run_op(OP_CLEAR, 20'h00000, 16'h0000);
        run_op(OP_ERASE, 20'h08010, 16'h0000);
        chk({rsp_fault, rsp_status}, {1'b0, 16'h0080});
        rd_chk(20'h08010, 16'hFFFF);
    endtask

    task automatic t_sleep();
        @(posedge ref_clk);
        write_protect <= 1'b1;
        run_op(OP_PROGRAM, 20'h00020, 16'h0000);
        chk(rsp_status, 16'h0092);
        run_op(OP_SLEEP, 20'h00000, 16'h0000);
        chk({ctl.reset_powerdown_n, ctl.ce_n}, 2'b01);
        rd_chk(20'h09020, 16'hA5A5);
        chk(lat, 16);
        run_op(OP_STATUS, 20'h00000, 16'h0000);
        chk(rsp_data, 16'h0080);
        rd_chk(20'h09020, 16'hA5A5);
    endtask

    initial begin
        t_reset();
        t_program();
        t_lock();
        t_supply();
        t_sleep();
        results();
    end

endmodule // fpc_host_tb

`default_nettype wire
